//--- tod_capture_pkg.sv
// Behaviour
// - capture on pin edge or chip-select fall
// - any pin selectable as capture trigger
// - capture latches counter into 40-bit field
// - host reads LSB to re-arm capture
// - count clock pll2/20 or pll3/8
// - source select 0 pll3, 1 pll2
// - trigger select 1 pin, 0 chip select
// - enable bit activates counting and capture
// - chip-select fall captures unless blocked
// - msb read blocks chip-select captures until lsb
// - one multibyte read captures and re-arms
// - pin function code 0x27 selects capture pin
// - pin captures blocked until lsb read
// - capture value shown as five byte registers
// - counter counts up, wraps to zero
// - disabled counter held at zero
// - polarity invert 0 means rising edge
package tod_capture_pkg;
  localparam int COUNT_W = 40;
  localparam int NUM_PINS = 8;
  localparam int PIN_IDX_W = 3;
  localparam int MODE_W = 8;
  localparam int BYTE_W = 8;
  localparam int NUM_BYTES = 5;
  localparam logic [MODE_W-1:0] TIME_CAPTURE_PIN_FUNCTION = 8'h27;
  localparam int PLL2_DIV = 20;
  localparam int PLL3_DIV = 8;
  localparam int DIV_W = 5;
  localparam logic SRC_PLL3 = 1'h0;
  localparam logic SRC_PLL2 = 1'h1;
  localparam logic TRIG_CHIP_SELECT = 1'h0;
  localparam logic TRIG_PIN = 1'h1;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 40'h00_0000_0000;
  localparam logic [DIV_W-1:0] DIV_RESET = 5'h00;
  typedef enum logic {ARMED, BLOCKED} cap_state_t;
endpackage : tod_capture_pkg

//--- time_of_day_capture_counter.sv
`timescale 1ns/100ps
`default_nettype none
module time_of_day_capture_counter import tod_capture_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic pll2VcoTick,
  input wire logic pll3VcoTick,
  input wire logic countClockSourceSelect,
  input wire logic captureTriggerSelect,
  input wire logic timeCounterEnable,
  input wire logic [NUM_PINS*MODE_W-1:0] pinFunctionSelect,
  input wire logic [NUM_PINS-1:0] pinPolarityInvert,
  input wire logic [NUM_PINS-1:0] pinIn,
  input wire logic serialChipSelect_b,
  input wire logic readMsbStrobe,
  input wire logic readLsbStrobe,
  output logic [COUNT_W-1:0] capturedTimeCount,
  output logic [COUNT_W-1:0] timeCount,
  output logic captureBlocked,
  output logic capturePulse
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] captured;
    logic [NUM_PINS-1:0] pinSync1;
    logic [NUM_PINS-1:0] pinSync2;
    logic [NUM_PINS-1:0] pinPrev;
    logic csSync1;
    logic csSync2;
    logic csPrev;
    cap_state_t capState;
    logic capPulse;
  } state_t;

  state_t st;
  state_t next_st;

  // ==========================================================
  // helpers
  function automatic logic isCapturePin(input logic [NUM_PINS*MODE_W-1:0] modes, input int idx);
    isCapturePin = (modes[idx*MODE_W +: MODE_W] == TIME_CAPTURE_PIN_FUNCTION);
  endfunction : isCapturePin

  logic divTick;
  logic [DIV_W-1:0] divLast;
  logic srcTick;
  logic [NUM_PINS-1:0] activeLevel;
  logic [NUM_PINS-1:0] activePrev;
  logic pinEvent;
  logic csEvent;
  logic trigEvent;
  logic blocked;

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    srcTick = (countClockSourceSelect == SRC_PLL2) ? pll2VcoTick : pll3VcoTick;
    divLast = (countClockSourceSelect == SRC_PLL2) ? DIV_W'(PLL2_DIV - 1) : DIV_W'(PLL3_DIV - 1);
    divTick = srcTick && (st.div >= divLast);
    // polarity folded in so the edge detector only looks for rising levels
    activeLevel = st.pinSync2 ^ pinPolarityInvert;
    activePrev = st.pinPrev ^ pinPolarityInvert;
    pinEvent = 1'h0;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (isCapturePin(pinFunctionSelect, i) && activeLevel[i] && !activePrev[i]) begin
        pinEvent = 1'h1;
      end
    end
    csEvent = st.csPrev && !st.csSync2;
    trigEvent = (captureTriggerSelect == TRIG_PIN) ? pinEvent : csEvent;
    blocked = (st.capState == BLOCKED);
    next_st.pinSync1 = pinIn;
    next_st.pinSync2 = st.pinSync1;
    next_st.pinPrev = st.pinSync2;
    next_st.csSync1 = serialChipSelect_b;
    next_st.csSync2 = st.csSync1;
    next_st.csPrev = st.csSync2;
    next_st.capPulse = 1'h0;
    if (!timeCounterEnable) begin
      next_st.count = COUNT_RESET;
      next_st.div = DIV_RESET;
      next_st.capState = ARMED;
    end else begin
      if (srcTick) begin
        next_st.div = divTick ? DIV_RESET : st.div + DIV_W'(1);
      end
      if (divTick) begin
        next_st.count = st.count + COUNT_W'(1);
      end
      case (st.capState)
        ARMED: begin
          if (trigEvent) begin
            next_st.captured = st.count;
            next_st.capPulse = 1'h1;
            if (captureTriggerSelect == TRIG_PIN) begin
              next_st.capState = BLOCKED;
            end
          end
        end
        BLOCKED: begin
          next_st.capState = BLOCKED;
        end
        default: begin
          next_st.capState = ARMED;
        end
      endcase
      // msb read blocks at once: the frame that read it already used the value
      // latched at its own chip-select fall, so later falls must not overwrite it
      if ((captureTriggerSelect == TRIG_CHIP_SELECT) && readMsbStrobe) begin
        next_st.capState = BLOCKED;
      end
      // lsb read re-arms; within one multibyte read this wins
      if (readLsbStrobe) begin
        next_st.capState = ARMED;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st <= '0;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign capturedTimeCount = st.captured;
  assign timeCount = st.count;
  assign captureBlocked = logic'(st.capState);
  assign capturePulse = st.capPulse;

  // ==========================================================
  // checks

  // ==========================================================
  // sequences
  sequence s_armed_trigger;
    clkEn && timeCounterEnable && trigEvent && !blocked;
  endsequence

  sequence s_latched;
    capturePulse && (st.captured == $past(st.count));
  endsequence

  sequence s_cs_fall_armed;
    clkEn && timeCounterEnable && (captureTriggerSelect == TRIG_CHIP_SELECT) && !blocked && csEvent;
  endsequence

  // ==========================================================
  // counter checks
  a_disabled_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (clkEn && !timeCounterEnable)
      |=> (st.count == COUNT_RESET)
  ) else begin
    $error("counter not held at zero");
  end

  a_count_step: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (clkEn && timeCounterEnable && !divTick)
      |=> $stable(st.count)
  ) else begin
    $error("counter moved without tick");
  end

  a_count_inc: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (clkEn && timeCounterEnable && divTick)
      |=> (st.count == $past(st.count) + COUNT_W'(1))
  ) else begin
    $error("counter did not increment");
  end

  a_div_range: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    1'h1
      |-> (st.div < DIV_W'(PLL2_DIV))
  ) else begin
    $error("divider out of range");
  end

  // clock enable low must freeze everything, synchronisers included
  a_clock_freeze: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    !clkEn
      |=> $stable(st)
  ) else begin
    $error("state moved while frozen");
  end

  // ==========================================================
  // synchroniser checks
  a_cs_sync_chain: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    clkEn
      |=> (st.csSync2 == $past(st.csSync1)) && (st.csPrev == $past(st.csSync2))
  ) else begin
    $error("chip select chain broken");
  end

  a_pin_sync_chain: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    clkEn
      |=> (st.pinSync2 == $past(st.pinSync1)) && (st.pinPrev == $past(st.pinSync2))
  ) else begin
    $error("pin chain broken");
  end

  a_pin_event_edge: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    pinEvent
      |-> ((st.pinSync2 ^ st.pinPrev) != '0)
  ) else begin
    $error("pin event without edge");
  end

  // ==========================================================
  // capture checks
  a_capture_value: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    s_armed_trigger
      |=> s_latched
  ) else begin
    $error("capture value wrong");
  end

  a_blocked_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (blocked && !readLsbStrobe)
      |=> $stable(st.captured)
  ) else begin
    $error("capture changed while blocked");
  end

  a_blocked_quiet: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (clkEn && timeCounterEnable && blocked)
      |=> !capturePulse
  ) else begin
    $error("capture while blocked");
  end

  a_lsb_rearm: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (clkEn && timeCounterEnable && readLsbStrobe)
      |=> !captureBlocked
  ) else begin
    $error("lsb read did not re-arm");
  end

  a_pin_blocks: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (clkEn && timeCounterEnable && (captureTriggerSelect == TRIG_PIN) && pinEvent && !blocked && !readLsbStrobe)
      |=> captureBlocked
  ) else begin
    $error("pin capture did not block");
  end

  a_msb_blocks: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (clkEn && timeCounterEnable && (captureTriggerSelect == TRIG_CHIP_SELECT) && readMsbStrobe && !readLsbStrobe)
      |=> captureBlocked
  ) else begin
    $error("msb read did not block");
  end

  a_cs_sync: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    s_cs_fall_armed
      |=> capturePulse
  ) else begin
    $error("chip select fall did not capture");
  end

  a_cs_only_fall: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (clkEn && timeCounterEnable && (captureTriggerSelect == TRIG_CHIP_SELECT) && !csEvent)
      |=> !capturePulse
  ) else begin
    $error("capture without chip select fall");
  end

  a_pin_only: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (clkEn && timeCounterEnable && (captureTriggerSelect == TRIG_PIN) && !pinEvent)
      |=> !capturePulse
  ) else begin
    $error("capture without pin edge");
  end

  a_disabled_armed: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (clkEn && !timeCounterEnable)
      |=> (!captureBlocked && !capturePulse)
  ) else begin
    $error("capture active while disabled");
  end
endmodule : time_of_day_capture_counter
`default_nettype wire

//--- host_trigger_model.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// serial host and trigger source
module host_trigger_model (
  input wire logic clk_sys,
  output logic [7:0] pinIn,
  output logic serialChipSelect_b,
  output logic readMsbStrobe,
  output logic readLsbStrobe,
  output logic vcoTick
);
  initial begin
    pinIn = 8'h00;
    serialChipSelect_b = 1'h1;
    readMsbStrobe = 1'h0;
    readLsbStrobe = 1'h0;
    vcoTick = 1'h0;
  end
  // vco ticks every other cycle, slow enough to count exactly
  always @(posedge clk_sys) vcoTick <= #1 ~vcoTick;
  task automatic pinSet(input logic [7:0] v);
    @(posedge clk_sys);
    #1 pinIn = v;
  endtask : pinSet
  // lsb byte is read last, which re-arms capture
  task automatic frame(input logic msb, input logic lsb);
    @(posedge clk_sys);
    #1 serialChipSelect_b = 1'h0;
    repeat (6) @(posedge clk_sys);
    #1 readMsbStrobe = msb;
    @(posedge clk_sys);
    #1 readMsbStrobe = 1'h0;
    readLsbStrobe = lsb;
    @(posedge clk_sys);
    #1 readLsbStrobe = 1'h0;
    serialChipSelect_b = 1'h1;
  endtask : frame
endmodule : host_trigger_model
`default_nettype wire

//--- tb_time_of_day_capture_counter.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// capture counter bench
module tb_time_of_day_capture_counter import tod_capture_pkg::*;;
  logic clk_sys = 1'h0;
  logic rst_b = 1'h0;
  logic srcSel = 1'h0;
  logic trigSel = 1'h1;
  logic enable = 1'h0;
  logic clkEnable = 1'h1;
  logic [7:0] polInv = 8'h00;
  logic [7:0] pinIn;
  logic csB, rdMsb, rdLsb, tick, blocked, pulse;
  logic [COUNT_W-1:0] captured, timeCount, cap1, t0, p0;
  logic [COUNT_W-1:0] pulses = 40'h0;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  host_trigger_model peer_u (.clk_sys(clk_sys), .pinIn(pinIn), .serialChipSelect_b(csB),
    .readMsbStrobe(rdMsb), .readLsbStrobe(rdLsb), .vcoTick(tick));
  time_of_day_capture_counter dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .clkEn(clkEnable),
    .pll2VcoTick(tick), .pll3VcoTick(tick), .countClockSourceSelect(srcSel),
    .captureTriggerSelect(trigSel), .timeCounterEnable(enable),
    .pinFunctionSelect({40'h0, TIME_CAPTURE_PIN_FUNCTION, 16'h0}), .pinPolarityInvert(polInv),
    .pinIn(pinIn), .serialChipSelect_b(csB), .readMsbStrobe(rdMsb), .readLsbStrobe(rdLsb),
    .capturedTimeCount(captured), .timeCount(timeCount), .captureBlocked(blocked),
    .capturePulse(pulse));
  task automatic chk(input logic [COUNT_W-1:0] got, input logic [COUNT_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : waitCyc
  task automatic stop_test();
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic pinScenario();
    p0 = pulses;
    peer_u.pinSet(8'h04);
    waitCyc(8);
    chk(pulses - p0, 1);
    chk(timeCount - captured < 40'h3, 1);
    cap1 = captured;
    waitCyc(20);
    peer_u.pinSet(8'h00);
    peer_u.pinSet(8'h04);
    waitCyc(8);
    chk(captured, cap1);
    peer_u.frame(1'h0, 1'h1);
    waitCyc(4);
    chk(blocked, 1'h0);
    polInv = 8'h04;
    peer_u.pinSet(8'h00);
    waitCyc(8);
    chk(pulses - p0, 2);
  endtask : pinScenario
  task automatic offScenario();
    enable = 1'h0;
    waitCyc(4);
    chk(timeCount, COUNT_RESET);
    chk(blocked, 1'h0);
    enable = 1'h1;
  endtask : offScenario
  task automatic csScenario();
    int expCnt[5] = '{1, 1, 1, 1, 2};
    logic [4:0] expBlk = 5'h07;
    trigSel = TRIG_CHIP_SELECT;
    p0 = pulses;
    for (int i = 0; i < 5; i++) begin
      peer_u.frame(i == 0 || i > 2, i > 2);
      waitCyc(6);
      chk(pulses - p0, expCnt[i]);
      chk(blocked, expBlk[i]);
    end
    chk(blocked, 1'h0);
  endtask : csScenario
  task automatic freezeScenario();
    clkEnable = 1'h0;
    t0 = timeCount;
    waitCyc(40);
    chk(timeCount, t0);
    clkEnable = 1'h1;
    waitCyc(40);
    chk(timeCount == t0, 1'h0);
  endtask : freezeScenario
  task automatic rateScenario();
    for (int s = 0; s < 2; s++) begin
      srcSel = s[0];
      enable = 1'h0;
      waitCyc(2);
      enable = 1'h1;
      waitCyc(100);
      t0 = timeCount;
      waitCyc(320);
      chk(timeCount - t0, 160 / (s ? PLL2_DIV : PLL3_DIV));
    end
  endtask : rateScenario
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (pulse === 1'h1) pulses <= pulses + 1;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    waitCyc(3);
    rst_b = 1'h1;
    enable = 1'h1;
    waitCyc(40);
    pinScenario();
    offScenario();
    csScenario();
    freezeScenario();
    rateScenario();
    stop_test();
  end
endmodule : tb_time_of_day_capture_counter
`default_nettype wire
